/* dv/cpu_bus_model.sv */
/*
 * Processor-side request model for the region attribute map.
 * Assumes the map samples requests on the rising edge of ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
	import region_map_pkg::*;
(
	input wire logic ref_clk, // System clock
	output logic req_valid, // Access presented
	output logic [ADDR_W-1:0] req_addr, // Physical address
	output logic [1:0] req_cpu, // Issuing processor
	output logic req_write, // Write access
	output logic req_locked, // Bus-lock held
	output logic req_dma, // DMA master
	output logic flush_cycle, // Flush bus cycle
	output logic wb_cycle // Write-back bus cycle
);
	initial begin
		{req_valid, req_write, req_locked, req_dma} = 4'h0;
		{flush_cycle, wb_cycle} = 2'b00;
		req_addr = 32'h0000_0000;
		req_cpu = 2'b00;
	end

	// f = {valid, write, locked, dma, flush, wback}; one request per cycle
	task automatic issue(input logic [31:0] a, input logic [1:0] c,
		input logic [5:0] f);
		@(negedge ref_clk);
		{req_valid, req_write, req_locked, req_dma} = f[5:2];
		{flush_cycle, wb_cycle} = f[1:0];
		req_addr = a;
		req_cpu = c;
	endtask

	// Released lines show the inverse, so stale values never look valid
	task automatic idle();
		@(negedge ref_clk);
		{req_valid, req_write, req_locked, req_dma} = 4'h0;
		{flush_cycle, wb_cycle} = 2'b00;
		req_addr = ~req_addr;
		req_cpu = ~req_cpu;
	endtask
endmodule
`default_nettype wire

/* dv/memory_region_attribute_map_tb_top.sv */
/*
 * Self-checking bench for the region attribute map.
 * Assumes one 40 MHz clock and results one cycle after each request.
 */
`timescale 1ns/1ps
`default_nettype none
module memory_region_attribute_map_tb_top
	import region_map_pkg::*;
;
	// ---------------------------------------------------------------
	// Clock, reset, wiring
	// ---------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [31:0] mem_limit = MEM_LIMIT_RST;
	logic rsvd_cacheable = 1'b0;
	logic init_cacheable = 1'b0;
	logic req_valid, req_write, req_locked, req_dma, flush_cycle, wb_cycle;
	logic [31:0] req_addr, attr_addr, snoop_addr;
	logic [1:0] req_cpu;
	logic attr_valid, attr_shared, attr_cacheable, attr_write;
	region_e attr_region;
	logic [3:0] local_unit_sel, cache_flush, cache_wback, snoop_inval;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	always #12.5 ref_clk = ~ref_clk;

	cpu_bus_model u_cpu_bus_model (.ref_clk(ref_clk), .req_valid(req_valid),
		.req_addr(req_addr), .req_cpu(req_cpu), .req_write(req_write),
		.req_locked(req_locked), .req_dma(req_dma),
		.flush_cycle(flush_cycle), .wb_cycle(wb_cycle));

	memory_region_attribute_map u_memory_region_attribute_map (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_addr(req_addr), .req_cpu(req_cpu), .req_write(req_write),
		.req_locked(req_locked), .req_dma(req_dma),
		.flush_cycle(flush_cycle), .wb_cycle(wb_cycle),
		.mem_limit(mem_limit), .rsvd_cacheable(rsvd_cacheable),
		.init_cacheable(init_cacheable), .attr_valid(attr_valid),
		.attr_region(attr_region), .attr_shared(attr_shared),
		.attr_cacheable(attr_cacheable), .attr_write(attr_write),
		.attr_addr(attr_addr), .local_unit_sel(local_unit_sel),
		.cache_flush(cache_flush), .cache_wback(cache_wback),
		.snoop_inval(snoop_inval), .snoop_addr(snoop_addr));

	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_attr(input region_e r, input logic s, input logic c);
		check(32'(attr_region), 32'(r));
		check(32'(attr_shared), 32'(s));
		check(32'(attr_cacheable), 32'(c));
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			finish_test();
		end
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	// Row: address, class, code {shared, follows strap, cacheable}.
	// Init straps run inverted to the reserved ones, so a swap shows.
	logic [38:0] rows [20] = '{
		{32'h0000_0000, REG_LOW_MAIN, 3'b101},
		{32'h0009_FFFF, REG_LOW_MAIN, 3'b101},
		{32'h000A_0000, REG_VIDEO, 3'b100},
		{32'h000B_FFFF, REG_VIDEO, 3'b100},
		{32'h000C_0000, REG_OPTROM, 3'b101},
		{32'h000D_FFFF, REG_OPTROM, 3'b101},
		{32'h000E_0000, REG_SYSFW, 3'b101},
		{32'h000F_FFFF, REG_SYSFW, 3'b101},
		{32'h0010_0000, REG_EXT_MAIN, 3'b101},
		{32'hFEBF_FFFF, REG_EXT_MAIN, 3'b101},
		{32'hFEC0_0000, REG_IO_UNIT, 3'b100},
		{32'hFECF_FFFF, REG_IO_UNIT, 3'b100},
		{32'hFED0_0000, REG_RSVD_LO, 3'b110},
		{32'hFEDF_FFFF, REG_RSVD_LO, 3'b110},
		{32'hFEE0_0000, REG_LOCAL_UNIT, 3'b000},
		{32'hFEEF_FFFF, REG_LOCAL_UNIT, 3'b000},
		{32'hFEF0_0000, REG_RSVD_HI, 3'b110},
		{32'hFFFD_FFFF, REG_RSVD_HI, 3'b110},
		{32'hFFFE_0000, REG_INIT_FW, 3'b111},
		{32'hFFFF_FFFF, REG_INIT_FW, 3'b111}};

	task automatic t_map();
		for (int s = 0; s < 2; s++) begin
			rsvd_cacheable = s[0];
			init_cacheable = !s[0];
			for (int i = 0; i < 20; i++) begin
				u_cpu_bus_model.issue(rows[i][38:7], 2'b01, 6'h20);
				u_cpu_bus_model.idle();
				check(32'(attr_valid), 32'h0000_0001);
				chk_attr(region_e'(rows[i][6:3]), rows[i][2],
					rows[i][1] ? (s[0] ^ rows[i][0]) : rows[i][0]);
			end
		end
	endtask

	task automatic t_local();
		for (int c = 0; c < 4; c++) begin
			u_cpu_bus_model.issue(32'hFEE0_0010, 2'(c), 6'h20);
			u_cpu_bus_model.idle();
			check(32'(local_unit_sel), 32'(4'h1 << c));
		end
		u_cpu_bus_model.issue(32'hFEC0_0010, 2'b10, 6'h20);
		u_cpu_bus_model.idle();
		check(32'(local_unit_sel), 32'h0000_0000);
	endtask

	task automatic t_lock_limit();
		u_cpu_bus_model.issue(32'h0010_0000, 2'b00, 6'h28);
		u_cpu_bus_model.idle();
		chk_attr(REG_EXT_MAIN, 1'b1, 1'b0);
		mem_limit = 32'h0FFF_FFFF;
		u_cpu_bus_model.issue(32'h1000_0000, 2'b00, 6'h20);
		u_cpu_bus_model.issue(32'h0FFF_FFFF, 2'b00, 6'h20);
		chk_attr(REG_MMIO_TOP, 1'b1, 1'b0);
		u_cpu_bus_model.idle();
		chk_attr(REG_EXT_MAIN, 1'b1, 1'b1);
		mem_limit = MEM_LIMIT_RST;
	endtask

	task automatic t_flush();
		u_cpu_bus_model.issue(32'h0000_0000, 2'b01, 6'h02);
		u_cpu_bus_model.issue(32'h0000_0000, 2'b11, 6'h01);
		check(32'({cache_flush, cache_wback}), 32'h0000_0020);
		u_cpu_bus_model.idle();
		check(32'({cache_flush, cache_wback}), 32'h0000_0008);
		u_cpu_bus_model.idle();
		check(32'({cache_flush, cache_wback}), 32'h0000_0000);
	endtask

	task automatic t_snoop_order();
		u_cpu_bus_model.issue(32'h0000_1000, 2'b01, 6'h30);
		u_cpu_bus_model.issue(32'h0020_0000, 2'b10, 6'h34);
		check(32'(snoop_inval), 32'h0000_000D);
		check(attr_addr, 32'h0000_1000);
		u_cpu_bus_model.issue(32'h000A_0000, 2'b00, 6'h30);
		check(32'(snoop_inval), 32'h0000_000F);
		check(snoop_addr, 32'h0020_0000);
		u_cpu_bus_model.idle();
		check(32'({snoop_inval, attr_write}), 32'h0000_0001);
	endtask

	initial begin
		repeat (4) @(negedge ref_clk);
		check(32'(attr_valid), 32'h0000_0000);
		sys_rst = 1'b0;
		t_map();
		t_local();
		t_lock_limit();
		t_flush();
		t_snoop_order();
		finish_test();
	end
endmodule
`default_nettype wire

/* verilog/memory_region_attribute_map.sv */
/*
 * Region attribute map with external-cache coherency controls.
 * Classifies each request one cycle after it is presented and issues
 * flush, write-back and snoop-invalidate strobes to the external caches.
 * Assumes requesters and caches run on ref_clk; no software registers.
 */
// Notes on behaviour
// - Interrupt-unit windows sit at fixed default bases, I/O and local.
// - I/O interrupt window is shared by all processors and never cached.
// - Local interrupt window goes to the issuer's unit, private, uncached.
// - Video buffer window is shared and uncached.
// - Add-on firmware window is shared and cacheable.
// - Extended memory from 1 MB to installed limit is shared and cacheable.
// - Both reserved device windows are shared; cacheability is a strap.
// - Memory-mapped device space is shared unless one exists per processor.
// - Memory starts at zero contiguously; devices sit at the top.
// - Caches stay coherent with each other, memory and DMA masters.
// - Processor flush and write-back cycles are passed to caches.
// - A flush only targets the issuing processor's cache.
// - Locked operations bypass caches so all processors see them.
// - Writes leave in exactly the order they were issued.
`timescale 1ns/1ps
`default_nettype none
module memory_region_attribute_map
	import region_map_pkg::*;
#(
	parameter int NUM_CPU = 4,
	parameter int CPU_W = 2
) (
	input wire logic ref_clk, // System clock, 40 MHz
	input wire logic sys_rst, // Async reset, active high
	input wire logic req_valid, // Access presented this cycle
	input wire logic [ADDR_W-1:0] req_addr, // Physical address
	input wire logic [CPU_W-1:0] req_cpu, // Issuing processor
	input wire logic req_write, // Access is a write
	input wire logic req_locked, // Bus-lock held for this access
	input wire logic req_dma, // Issued by a DMA master
	input wire logic flush_cycle, // Processor flush bus cycle
	input wire logic wb_cycle, // Processor write-back bus cycle
	input wire logic [ADDR_W-1:0] mem_limit, // Last installed byte
	input wire logic rsvd_cacheable, // Reserved windows may be cached
	input wire logic init_cacheable, // Init firmware may be cached
	output logic attr_valid, // Attributes valid
	output region_e attr_region, // Region class
	output logic attr_shared, // Shared by all processors
	output logic attr_cacheable, // Cacheable for this access
	output logic attr_write, // Access is a write
	output logic [ADDR_W-1:0] attr_addr, // Address of the access
	output logic [NUM_CPU-1:0] local_unit_sel, // Local unit target
	output logic [NUM_CPU-1:0] cache_flush, // Flush strobe per cache
	output logic [NUM_CPU-1:0] cache_wback, // Write-back per cache
	output logic [NUM_CPU-1:0] snoop_inval, // Invalidate per cache
	output logic [ADDR_W-1:0] snoop_addr // Line to invalidate
);

	// Elaboration check: every processor needs an index on req_cpu
	if (NUM_CPU < 1 || CPU_W < 1 || NUM_CPU > (1 << CPU_W)) begin : g_bad_cpu
		$error("NUM_CPU does not fit CPU_W");
	end

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	region_if rif ();

	assign rif.addr = req_addr;
	assign rif.mem_limit = mem_limit;
	assign rif.rsvd_cacheable = rsvd_cacheable;
	assign rif.init_cacheable = init_cacheable;

	region_decoder u_dec (
		.rif(rif)
	);

	logic [NUM_CPU-1:0] cpu_onehot;
	always_comb begin
		cpu_onehot = '0;
		cpu_onehot[req_cpu] = 1'b1;
	end

	// ---------------------------------------------------------------
	// Attribute stage
	// ---------------------------------------------------------------
	// A single in-order stage keeps writes in issue order; no buffering
	// means no reordering hazard, at the cost of no write posting.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			attr_valid <= 1'b0;
			attr_region <= REG_LOW_MAIN;
			attr_shared <= 1'b0;
			attr_cacheable <= 1'b0;
			attr_write <= 1'b0;
			attr_addr <= '0;
		end else begin
			attr_valid <= req_valid;
			attr_write <= req_write;
			attr_addr <= req_addr;
			attr_region <= rif.region;
			attr_shared <= rif.shared;
			// Locked traffic goes to memory so every processor sees it
			attr_cacheable <= rif.cacheable && !req_locked;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			local_unit_sel <= '0;
		end else if (req_valid && rif.region == REG_LOCAL_UNIT) begin
			local_unit_sel <= cpu_onehot;
		end else begin
			local_unit_sel <= '0;
		end
	end

	// ---------------------------------------------------------------
	// Cache coherency strobes
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cache_flush <= '0;
			cache_wback <= '0;
		end else begin
			cache_flush <= flush_cycle ? cpu_onehot : '0;
			cache_wback <= wb_cycle ? cpu_onehot : '0;
		end
	end

	// Writes into cacheable shared space invalidate every other copy;
	// a DMA write has no cache of its own, so all caches are hit.
	logic snoop_hit;
	assign snoop_hit = req_valid && req_write && rif.cacheable;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			snoop_inval <= '0;
			snoop_addr <= '0;
		end else begin
			snoop_addr <= req_addr;
			if (!snoop_hit) begin
				snoop_inval <= '0;
			end else if (req_dma) begin
				snoop_inval <= '1;
			end else begin
				snoop_inval <= ~cpu_onehot;
			end
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_io_unit_attr: assert property (
		req_valid && req_addr >= IO_UNIT_BASE && req_addr <= IO_UNIT_LAST
		|=> attr_region == REG_IO_UNIT && attr_shared && !attr_cacheable)
		else $error("I/O interrupt window attributes wrong");

	a_local_unit_attr: assert property (
		req_valid && req_addr >= LOCAL_UNIT_BASE
		&& req_addr <= LOCAL_UNIT_LAST
		|=> !attr_shared && !attr_cacheable
		&& local_unit_sel == $past(cpu_onehot))
		else $error("Local interrupt window not routed to issuer");

	a_video_attr: assert property (
		req_valid && req_addr >= VIDEO_BASE && req_addr <= VIDEO_LAST
		|=> attr_region == REG_VIDEO && attr_shared && !attr_cacheable)
		else $error("Video window attributes wrong");

	a_optrom_attr: assert property (
		req_valid && !req_locked && req_addr >= OPTROM_BASE
		&& req_addr <= OPTROM_LAST
		|=> attr_region == REG_OPTROM && attr_shared && attr_cacheable)
		else $error("Option firmware window attributes wrong");

	a_ext_main_attr: assert property (
		req_valid && !req_locked && req_addr >= EXT_MAIN_BASE
		&& req_addr <= mem_limit && req_addr <= EXT_MAIN_LAST
		|=> attr_region == REG_EXT_MAIN && attr_cacheable)
		else $error("Extended memory attributes wrong");

	a_rsvd_shared: assert property (
		req_valid && ((req_addr >= RSVD_LO_BASE && req_addr <= RSVD_LO_LAST)
		|| (req_addr >= RSVD_HI_BASE && req_addr <= RSVD_HI_LAST))
		|=> attr_shared && attr_cacheable == ($past(rsvd_cacheable)
		&& !$past(req_locked)))
		else $error("Reserved window attributes wrong");

	a_locked_uncached: assert property (
		req_valid && req_locked |=> !attr_cacheable)
		else $error("Locked access left cacheable");

	a_flush_issuer: assert property (
		flush_cycle |=> $onehot(cache_flush)
		&& cache_flush == $past(cpu_onehot))
		else $error("Flush reached a foreign cache");

	a_write_order: assert property (
		req_valid && req_write ##1 req_valid && req_write
		|=> attr_write && attr_addr == $past(req_addr)
		&& $past(attr_addr) == $past(req_addr, 2))
		else $error("Write order not preserved");

	a_snoop_others: assert property (
		req_valid && req_write && !req_dma && rif.cacheable
		|=> snoop_inval == ~$past(cpu_onehot))
		else $error("Snoop missed another cache");

	c_io_access: cover property (
		req_valid && rif.region == REG_IO_UNIT ##1 attr_valid);
	c_local_access: cover property (
		req_valid && rif.region == REG_LOCAL_UNIT);
	c_dma_snoop: cover property (req_valid && req_write && req_dma
		&& rif.cacheable ##1 snoop_inval == '1);
	c_flush: cover property (flush_cycle ##1 cache_flush != '0);

endmodule
`default_nettype wire

/* verilog/region_decoder.sv */
/*
 * Combinational address decoder: one region class and its attributes.
 * Assumes mem_limit lies inside the extended main-memory range.
 */
`timescale 1ns/1ps
`default_nettype none
module region_decoder
	import region_map_pkg::*;
(
	region_if.decoder rif // Address in, attributes out
);

	function automatic logic in_win(input logic [31:0] a,
		input logic [31:0] lo, input logic [31:0] hi);
		in_win = (a >= lo) && (a <= hi);
	endfunction

	// Interrupt-controller windows are tested first so they always win
	always_comb begin
		rif.region = REG_MMIO_TOP;
		rif.shared = 1'b1;
		rif.cacheable = 1'b0;
		if (in_win(rif.addr, IO_UNIT_BASE, IO_UNIT_LAST)) begin
			rif.region = REG_IO_UNIT;
		end else if (in_win(rif.addr, LOCAL_UNIT_BASE,
			LOCAL_UNIT_LAST)) begin
			rif.region = REG_LOCAL_UNIT;
			rif.shared = 1'b0;
		end else if (in_win(rif.addr, RSVD_LO_BASE, RSVD_LO_LAST)) begin
			rif.region = REG_RSVD_LO;
			rif.cacheable = rif.rsvd_cacheable;
		end else if (in_win(rif.addr, RSVD_HI_BASE, RSVD_HI_LAST)) begin
			rif.region = REG_RSVD_HI;
			rif.cacheable = rif.rsvd_cacheable;
		end else if (rif.addr >= INIT_FW_BASE) begin
			rif.region = REG_INIT_FW;
			rif.cacheable = rif.init_cacheable;
		end else if (in_win(rif.addr, LOW_MAIN_BASE, LOW_MAIN_LAST)) begin
			rif.region = REG_LOW_MAIN;
			rif.cacheable = 1'b1;
		end else if (in_win(rif.addr, VIDEO_BASE, VIDEO_LAST)) begin
			rif.region = REG_VIDEO;
		end else if (in_win(rif.addr, OPTROM_BASE, OPTROM_LAST)) begin
			rif.region = REG_OPTROM;
			rif.cacheable = 1'b1;
		end else if (in_win(rif.addr, SYSFW_BASE, SYSFW_LAST)) begin
			rif.region = REG_SYSFW;
			rif.cacheable = 1'b1;
		end else if (rif.addr <= rif.mem_limit) begin
			rif.region = REG_EXT_MAIN;
			rif.cacheable = 1'b1;
		end else begin
			// Above installed memory: shared device space, uncached
			rif.region = REG_MMIO_TOP;
		end
	end

endmodule
`default_nettype wire

/* verilog/region_if.sv */
/*
 * Interface between the attribute map top and its address decoder.
 * Assumes the decoder is purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
interface region_if;
	import region_map_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] mem_limit;
	logic rsvd_cacheable;
	logic init_cacheable;
	region_e region;
	logic shared;
	logic cacheable;

	modport decoder (
		input addr, mem_limit, rsvd_cacheable, init_cacheable,
		output region, shared, cacheable
	);
	modport user (
		output addr, mem_limit, rsvd_cacheable, init_cacheable,
		input region, shared, cacheable
	);
endinterface
`default_nettype wire

/* verilog/region_map_pkg.sv */
/*
 * Package of the region attribute map: window bounds, region classes
 * and the default installed-memory limit.
 * Assumes 32-bit physical addresses and a single system clock.
 */
package region_map_pkg;

	localparam int ADDR_W = 32;

	// ---------------------------------------------------------------
	// Window bounds
	// ---------------------------------------------------------------
	localparam logic [31:0] LOW_MAIN_BASE = 32'h0000_0000;
	localparam logic [31:0] LOW_MAIN_LAST = 32'h0009_FFFF;
	localparam logic [31:0] VIDEO_BASE = 32'h000A_0000;
	localparam logic [31:0] VIDEO_LAST = 32'h000B_FFFF;
	localparam logic [31:0] OPTROM_BASE = 32'h000C_0000;
	localparam logic [31:0] OPTROM_LAST = 32'h000D_FFFF;
	localparam logic [31:0] SYSFW_BASE = 32'h000E_0000;
	localparam logic [31:0] SYSFW_LAST = 32'h000F_FFFF;
	localparam logic [31:0] EXT_MAIN_BASE = 32'h0010_0000;
	localparam logic [31:0] EXT_MAIN_LAST = 32'hFEBF_FFFF;
	localparam logic [31:0] IO_UNIT_BASE = 32'hFEC0_0000;
	localparam logic [31:0] IO_UNIT_LAST = 32'hFECF_FFFF;
	localparam logic [31:0] RSVD_LO_BASE = 32'hFED0_0000;
	localparam logic [31:0] RSVD_LO_LAST = 32'hFEDF_FFFF;
	localparam logic [31:0] LOCAL_UNIT_BASE = 32'hFEE0_0000;
	localparam logic [31:0] LOCAL_UNIT_LAST = 32'hFEEF_FFFF;
	localparam logic [31:0] RSVD_HI_BASE = 32'hFEF0_0000;
	localparam logic [31:0] RSVD_HI_LAST = 32'hFFFD_FFFF;
	localparam logic [31:0] INIT_FW_BASE = 32'hFFFE_0000;

	// Default installed-memory limit: the whole extended range
	localparam logic [31:0] MEM_LIMIT_RST = EXT_MAIN_LAST;

	typedef enum logic [3:0] {
		REG_LOW_MAIN = 4'h0,
		REG_VIDEO = 4'h1,
		REG_OPTROM = 4'h2,
		REG_SYSFW = 4'h3,
		REG_EXT_MAIN = 4'h4,
		REG_MMIO_TOP = 4'h5,
		REG_IO_UNIT = 4'h6,
		REG_RSVD_LO = 4'h7,
		REG_LOCAL_UNIT = 4'h8,
		REG_RSVD_HI = 4'h9,
		REG_INIT_FW = 4'hA
	} region_e;

endpackage
